// file: src/scsm_cfg.svh
`ifndef SCSM_CFG_SVH
`define SCSM_CFG_SVH

`define SCSM_CTRL_ADDR      12'hf86
`define SCSM_UNLOCK_FIRST   8'he7
`define SCSM_UNLOCK_SECOND  8'h18
`define SCSM_CTRL_RESET     8'ha0
`define SCSM_BIT_IRC_EN     7
`define SCSM_BIT_XTAL_EN    6
`define SCSM_BIT_WDT_EN     5
`define SCSM_BIT_SOF_EN     4
`define SCSM_BIT_WDF_EN     3
`define SCSM_SEL_MSB        2
`define SCSM_SEL_IRC_FAST   3'h0
`define SCSM_SEL_IRC_SLOW   3'h1
`define SCSM_SEL_XTAL       3'h2
`define SCSM_SEL_WDT        3'h3
`define SCSM_SEL_EXT        3'h4
`define SCSM_CLK_MHZ        100
`define SCSM_PRI_FAIL_US    1000
`define SCSM_PRI_FAIL_CYC   (`SCSM_PRI_FAIL_US * `SCSM_CLK_MHZ)
`define SCSM_WDT_FAIL_TICKS 8004
`define SCSM_SWITCH_GAP     2

`endif

// file: src/scsm_clk_switch.sv
`timescale 1ns/1ps
`include "scsm_cfg.svh"
// Break-before-make gating of the system clock sources
module scsm_clk_switch #(
  parameter int NSRC = 5,
  parameter int GAP  = `SCSM_SWITCH_GAP
) (
  input  wire logic            core_clk,
  input  wire logic            rst,
  input  wire logic            clk_en,
  input  wire logic [2:0]      req_sel,
  input  wire logic            kill,
  output logic      [NSRC-1:0] gate,
  output logic                 busy
);
  localparam int GW = $clog2(GAP + 1);

  if (GAP < 1 || NSRC > 8) begin : g_chk
    $error("scsm_clk_switch: GAP >= 1 and NSRC <= 8 required");
  end

  logic [2:0]    cur_r;
  logic [GW-1:0] gap_r;
  logic          want;

  assign want = (int'(req_sel) < NSRC) && (req_sel != cur_r);
  assign busy = want || (gap_r != '0);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cur_r <= 3'h0;
      gap_r <= '0;
    end else if (clk_en) begin
      if (want && gap_r == '0) begin
        gap_r <= GW'(GAP);
      end else if (gap_r == GW'(1)) begin
        gap_r <= '0;
        cur_r <= (int'(req_sel) < NSRC) ? req_sel : cur_r;
      end else if (gap_r != '0) begin
        gap_r <= gap_r - GW'(1);
      end
    end
  end

  // Old gate drops before the gap, new one rises after it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gate <= NSRC'(1);
    end else if (clk_en) begin
      if (kill || want || gap_r != '0) begin // [RULE23]
        gate <= '0;
      end else begin
        gate <= NSRC'(1) << cur_r;
      end
    end
  end

  one_gate_a: assert property (@(posedge core_clk) disable iff (rst)
    $onehot0(gate)) else $error("more than one source gated"); // [RULE23]
endmodule

// file: src/scsm_edge_watch.sv
`timescale 1ns/1ps
// Counts ticks since the last watched edge; pulses on reaching the limit
module scsm_edge_watch #(
  parameter int LIMIT = 8004
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  input  wire logic enable,
  input  wire logic tick,
  input  wire logic edge_seen,
  output logic      timeout
);
  localparam int W = $clog2(LIMIT + 1);

  if (LIMIT < 2) begin : g_chk
    $error("scsm_edge_watch: LIMIT must be at least 2");
  end

  logic [W-1:0] cnt_r;
  logic         hit;

  assign hit = tick && (cnt_r == W'(LIMIT - 1));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (clk_en) begin
      if (!enable || edge_seen || hit) begin
        cnt_r <= '0;
      end else if (tick) begin
        cnt_r <= cnt_r + W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      timeout <= 1'b0;
    end else if (clk_en) begin
      timeout <= enable && !edge_seen && hit;
    end
  end

  timeout_cause_a: assert property (@(posedge core_clk) disable iff (rst)
    timeout |-> $past(enable) && $past(cnt_r) == W'(LIMIT - 1))
    else $error("timeout without full count");
endmodule

// file: src/scsm_pkg.sv
package scsm_pkg;
  typedef enum logic [1:0] {
    UNLK_IDLE,
    UNLK_FIRST,
    UNLK_OPEN
  } scsm_unlock_t;

  typedef enum logic [1:0] {
    OSC_IRC,
    OSC_XTAL,
    OSC_WDT,
    OSC_EXT
  } scsm_osc_t;
endpackage

// file: src/scsm_top.sv
`timescale 1ns/1ps
`include "scsm_cfg.svh"
// Operation
// RULE1: Control writes stay blocked until E7 then 18 are written.
// RULE2: First write after unlock updates the register and relocks it.
// RULE3: Any other write sequence leaves the register unchanged.
// RULE4: Unlock values in order, gaps and other accesses allowed.
// RULE5: Software turns off both failure detectors before switching source.
// RULE6: Detection may be re-enabled after a successful select write.
// RULE7: Precision oscillator on after reset; only software turns it off.
// RULE8: Primary failure with detection on raises event and moves to watchdog.
// RULE9: Recovery needs watchdog oscillator enabled, not watchdog reset.
// RULE10: Primary failure declared below about 1 kHz, plus or minus half.
// RULE11: Software keeps primary detection off for slow external clocks.
// RULE12: Watchdog oscillator failure raises event, clock source unchanged.
// RULE13: After watchdog oscillator failure primary detection stops working.
// RULE14: Software clears watchdog detection when it is unusable.
// RULE15: Watchdog failure after 8004 system clocks without its edge.
// RULE16: With detection and all working sources off the device stops.
// RULE17: Software enables crystal and waits before selecting it.
// RULE18: Software enables watchdog oscillator and waits before selecting it.
// RULE19: Bit 7 precision oscillator enable, bit 5 watchdog enable, both 1.
// RULE20: Bit 6 crystal enable resets 0 and overrides crystal pin I/O.
// RULE21: Bit 4 primary detection, bit 3 watchdog detection, both reset 0.
// RULE22: Bits 2..0 select source, reset 000, codes 101..111 reserved.
// RULE23: Source switches never glitch the system clock.
module scsm_top #(
  parameter int PRI_FAIL_CYC   = `SCSM_PRI_FAIL_CYC,
  parameter int WDT_FAIL_TICKS = `SCSM_WDT_FAIL_TICKS
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic [3:0]  osc_level,
  output logic             internal_rc_enable,
  output logic             crystal_enable,
  output logic             crystal_pin_override,
  output logic             watchdog_osc_enable,
  output logic      [4:0]  sysclk_gate,
  output logic             sysclk_fail_event,
  output logic             watchdog_osc_fail_event,
  output logic             clock_stopped
);
  import scsm_pkg::*;

  if (PRI_FAIL_CYC < 2 || WDT_FAIL_TICKS < 2) begin : g_chk
    $error("scsm_top: failure limits must be at least 2");
  end

  scsm_unlock_t unlk_r;
  scsm_unlock_t unlk_nxt;
  logic [7:0]   ctrl_r;
  logic [7:0]   ctrl_nxt;
  logic [3:0]   osc_prev_r;
  logic [3:0]   osc_rise;
  scsm_osc_t    sel_osc;
  logic         sel_rise;
  logic         sel_enabled;
  logic         ctrl_wr;
  logic         pri_timeout;
  logic         wdt_timeout;
  logic         pri_watch_en;
  logic         wdt_watch_en;
  logic         can_recover;
  logic         switch_busy;
  logic         wdt_failed_r;
  logic [2:0]   sel_field;

  assign ctrl_wr   = reg_wr && (reg_addr == `SCSM_CTRL_ADDR);
  assign sel_field = ctrl_r[`SCSM_SEL_MSB:0];

  // Per-source rising edge detect on synchronous oscillator levels
  for (genvar i = 0; i < 4; i++) begin : g_edge
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        osc_prev_r[i] <= 1'b0;
      end else if (clk_en) begin
        osc_prev_r[i] <= osc_level[i];
      end
    end
    assign osc_rise[i] = osc_level[i] && !osc_prev_r[i];
  end

  always_comb begin
    unique case (sel_field) // [RULE22]
      `SCSM_SEL_IRC_FAST: sel_osc = OSC_IRC;
      `SCSM_SEL_IRC_SLOW: sel_osc = OSC_IRC;
      `SCSM_SEL_XTAL:     sel_osc = OSC_XTAL;
      `SCSM_SEL_WDT:      sel_osc = OSC_WDT;
      `SCSM_SEL_EXT:      sel_osc = OSC_EXT;
      default:            sel_osc = OSC_IRC;
    endcase
  end

  assign sel_rise = osc_rise[sel_osc];

  always_comb begin
    unique case (sel_osc)
      OSC_IRC:  sel_enabled = ctrl_r[`SCSM_BIT_IRC_EN];
      OSC_XTAL: sel_enabled = ctrl_r[`SCSM_BIT_XTAL_EN];
      OSC_WDT:  sel_enabled = ctrl_r[`SCSM_BIT_WDT_EN];
      OSC_EXT:  sel_enabled = 1'b1;
    endcase
  end

  // Unlock sequencer; only writes to the control address move it
  always_comb begin
    unlk_nxt = unlk_r;
    if (ctrl_wr) begin
      unique case (unlk_r)
        UNLK_IDLE: begin
          unlk_nxt = (reg_wdata == `SCSM_UNLOCK_FIRST) ? UNLK_FIRST : UNLK_IDLE; // [RULE1]
        end
        UNLK_FIRST: begin
          if (reg_wdata == `SCSM_UNLOCK_SECOND) begin
            unlk_nxt = UNLK_OPEN; // [RULE1]
          end else if (reg_wdata == `SCSM_UNLOCK_FIRST) begin
            unlk_nxt = UNLK_FIRST;
          end else begin
            unlk_nxt = UNLK_IDLE; // [RULE3]
          end
        end
        UNLK_OPEN: begin
          unlk_nxt = UNLK_IDLE; // [RULE2]
        end
        default: begin
          unlk_nxt = UNLK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      unlk_r <= UNLK_IDLE;
    end else if (clk_en) begin
      unlk_r <= unlk_nxt; // [RULE4]
    end
  end

  // Recovery forces the watchdog source and wins over a software write
  assign can_recover = ctrl_r[`SCSM_BIT_WDT_EN] && !wdt_failed_r;

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (ctrl_wr && unlk_r == UNLK_OPEN) begin
      ctrl_nxt = reg_wdata; // [RULE2]
    end
    if (pri_timeout && can_recover) begin
      ctrl_nxt[`SCSM_SEL_MSB:0] = `SCSM_SEL_WDT; // [RULE8] [RULE9]
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= `SCSM_CTRL_RESET; // [RULE7] [RULE19] [RULE20] [RULE21] [RULE22]
    end else if (clk_en) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= (reg_rd && reg_addr == `SCSM_CTRL_ADDR) ? ctrl_r : 8'h00;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      internal_rc_enable   <= 1'b1;
      crystal_enable       <= 1'b0;
      crystal_pin_override <= 1'b0;
      watchdog_osc_enable  <= 1'b1;
    end else if (clk_en) begin
      internal_rc_enable   <= ctrl_nxt[`SCSM_BIT_IRC_EN]; // [RULE7] [RULE19]
      crystal_enable       <= ctrl_nxt[`SCSM_BIT_XTAL_EN]; // [RULE20]
      crystal_pin_override <= ctrl_nxt[`SCSM_BIT_XTAL_EN]; // [RULE20]
      watchdog_osc_enable  <= ctrl_nxt[`SCSM_BIT_WDT_EN]; // [RULE19]
    end
  end

  // Primary watch: core cycles between selected-source edges
  assign pri_watch_en = ctrl_r[`SCSM_BIT_SOF_EN] && !wdt_failed_r && !switch_busy; // [RULE13]

  scsm_edge_watch #(
    .LIMIT(PRI_FAIL_CYC)
  ) u_pri_watch (
    .core_clk (core_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .enable   (pri_watch_en),
    .tick     (1'b1),
    .edge_seen(sel_rise),
    .timeout  (pri_timeout)
  ); // [RULE10]

  // Watchdog watch: system clock edges between watchdog edges
  assign wdt_watch_en = ctrl_r[`SCSM_BIT_WDF_EN] && ctrl_r[`SCSM_BIT_WDT_EN] &&
                        (sel_osc != OSC_WDT) && !wdt_failed_r;

  scsm_edge_watch #(
    .LIMIT(WDT_FAIL_TICKS)
  ) u_wdt_watch (
    .core_clk (core_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .enable   (wdt_watch_en),
    .tick     (sel_rise),
    .edge_seen(osc_rise[OSC_WDT]),
    .timeout  (wdt_timeout)
  ); // [RULE15]

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wdt_failed_r <= 1'b0;
    end else if (clk_en && wdt_timeout) begin
      wdt_failed_r <= 1'b1; // [RULE13]
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sysclk_fail_event       <= 1'b0;
      watchdog_osc_fail_event <= 1'b0;
    end else if (clk_en) begin
      sysclk_fail_event       <= pri_timeout; // [RULE8]
      watchdog_osc_fail_event <= wdt_timeout; // [RULE12]
    end
  end

  // Selected source off and no recovery path: only reset restarts
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clock_stopped <= 1'b0;
    end else if (clk_en) begin
      if (!sel_enabled && !(ctrl_r[`SCSM_BIT_SOF_EN] && can_recover)) begin
        clock_stopped <= 1'b1; // [RULE16]
      end
    end
  end

  scsm_clk_switch #(
    .NSRC(5),
    .GAP (`SCSM_SWITCH_GAP)
  ) u_switch (
    .core_clk(core_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .req_sel (sel_field),
    .kill    (clock_stopped),
    .gate    (sysclk_gate),
    .busy    (switch_busy)
  ); // [RULE23]

  locked_no_change_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
    clk_en && ctrl_wr && unlk_r != UNLK_OPEN && !pri_timeout |=> $stable(ctrl_r))
    else $error("locked write changed control");

  open_write_relock_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE2]
    clk_en && ctrl_wr && unlk_r == UNLK_OPEN && !pri_timeout
    |=> ctrl_r == $past(reg_wdata) && unlk_r == UNLK_IDLE)
    else $error("unlocked write not applied or not relocked");

  bad_second_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE3]
    clk_en && ctrl_wr && unlk_r == UNLK_FIRST && reg_wdata != `SCSM_UNLOCK_SECOND
    |=> unlk_r != UNLK_OPEN)
    else $error("wrong second value unlocked");

  other_access_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE4]
    clk_en && !ctrl_wr |=> unlk_r == $past(unlk_r))
    else $error("foreign access moved unlock state");

  recover_switch_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE8]
    clk_en && pri_timeout && can_recover
    |=> sysclk_fail_event && sel_field == `SCSM_SEL_WDT)
    else $error("primary failure not recovered");

  no_recover_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE9]
    clk_en && pri_timeout && !ctrl_r[`SCSM_BIT_WDT_EN] && !(ctrl_wr && unlk_r == UNLK_OPEN)
    |=> $stable(sel_field))
    else $error("recovery without watchdog oscillator");

  wdt_event_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE12]
    clk_en && wdt_timeout && !ctrl_wr && !pri_timeout
    |=> watchdog_osc_fail_event && $stable(sel_field))
    else $error("watchdog failure event wrong");

  pri_dead_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE13]
    wdt_failed_r |=> !sysclk_fail_event [*3])
    else $error("primary event after watchdog failure");

  irc_stays_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE7]
    clk_en && !(ctrl_wr && unlk_r == UNLK_OPEN) && ctrl_r[`SCSM_BIT_IRC_EN]
    |=> ctrl_r[`SCSM_BIT_IRC_EN])
    else $error("precision oscillator dropped by hardware");

  stop_sticky_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE16]
    clock_stopped |=> clock_stopped && sysclk_gate == 5'h00)
    else $error("stopped state left without reset");
endmodule

// file: verification/scsm_osc_model.sv
`timescale 1ns/1ps
// Oscillator sources; a stopped source parks low
module scsm_osc_model (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [3:0] run,
  output logic      [3:0] osc_level
);
  logic [3:0] cnt_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // Periods 4, 8, 16 and 4 cycles; run low models a dead source
  assign osc_level = run & {cnt_r[1], cnt_r[3], cnt_r[2], cnt_r[1]};
endmodule

// file: verification/scsm_top_tb_top.sv
`timescale 1ns/1ps
module scsm_top_tb_top;
  localparam int          PRI  = 50;
  localparam int          WDT  = 20;
  localparam logic [11:0] CTRL = 12'hf86;

  logic        core_clk  = 1'b0;
  logic        rst       = 1'b1;
  logic [11:0] reg_addr  = 12'h000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        clk_en    = 1'b1;
  logic [3:0]  osc_run   = 4'hf;
  logic [7:0]  reg_rdata;
  logic [3:0]  osc_level;
  logic        internal_rc_enable;
  logic        crystal_enable;
  logic        crystal_pin_override;
  logic        watchdog_osc_enable;
  logic [4:0]  sysclk_gate;
  logic        sysclk_fail_event;
  logic        watchdog_osc_fail_event;
  logic        clock_stopped;
  logic [3:0]  en;
  logic [2:0]  evs;
  int          err_count = 0;
  int          tests_run = 0;

  assign en  = {internal_rc_enable, crystal_enable, watchdog_osc_enable, crystal_pin_override};
  assign evs = {clock_stopped, watchdog_osc_fail_event, sysclk_fail_event};

  scsm_top #(.PRI_FAIL_CYC(PRI), .WDT_FAIL_TICKS(WDT)) DUT (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .osc_level(osc_level), .internal_rc_enable(internal_rc_enable),
    .crystal_enable(crystal_enable), .crystal_pin_override(crystal_pin_override),
    .watchdog_osc_enable(watchdog_osc_enable), .sysclk_gate(sysclk_gate),
    .sysclk_fail_event(sysclk_fail_event),
    .watchdog_osc_fail_event(watchdog_osc_fail_event), .clock_stopped(clock_stopped));

  scsm_osc_model osc (.core_clk(core_clk), .rst(rst), .run(osc_run), .osc_level(osc_level));

  always #5 core_clk = ~core_clk;

  // More than one source gated at once is a glitch
  always @(posedge core_clk) begin
    if (!rst && $countones(sysclk_gate) > 1) begin
      err_count++;
      $display("FAIL gate_onehot exp one_hot got %h", sysclk_gate);
    end
  end

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  function automatic logic [7:0] gate_exp(input int s);
    return (s < 5) ? (8'h01 << s) : 8'h10;
  endfunction

  task automatic chk_val(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s exp %h got %h", name, exp, got);
    end
  endtask

  task automatic chk_rng(input string name, input int lo, input int hi, input int got);
    tests_run++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("FAIL %s exp %0d..%0d got %0d", name, lo, hi, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic wr_ctrl(input logic [7:0] d);
    wr(CTRL, 8'he7);
    wr(CTRL, 8'h18);
    wr(CTRL, d);
  endtask

  task automatic chk_ctrl(input string name, input logic [7:0] exp);
    logic [7:0] d;
    rd(CTRL, d);
    chk_val(name, exp, d);
  endtask

  task automatic wait_sig(input int which, input int lim, output int n);
    n = 0;
    while (n < lim) begin
      @(posedge core_clk);
      #1 n++;
      if (evs[which] === 1'b1) break;
    end
    if (evs[which] !== 1'b1) begin
      err_count++;
      $display("FAIL wait_evs%0d exp 1 got timeout", which);
      finish_test();
    end
  endtask

  task automatic do_reset;
    rst     <= 1'b1;
    osc_run <= 4'hf;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
  endtask

  task automatic finish_test;
    $display("err_count %0d tests_run %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    logic [7:0] d;
    logic [7:0] lf;
    int         n;
    do_reset();
    chk_ctrl("ctrl_reset", 8'ha0);
    chk_val("en_reset", 8'h0a, {4'h0, en});
    chk_val("gate_reset", 8'h01, {3'h0, sysclk_gate});
    rd(12'hf87, d);
    chk_val("unmapped", 8'h00, d);
    // Plain write, then a broken unlock pair
    wr(CTRL, 8'h55);
    wr(CTRL, 8'h18);
    wr(CTRL, 8'h5a);
    wr(CTRL, 8'he7);
    wr(CTRL, 8'h55);
    wr(CTRL, 8'h18);
    wr(CTRL, 8'h5a);
    chk_ctrl("locked", 8'ha0);
    wr_ctrl(8'ha0);
    // Unlock pair split by foreign traffic
    wr(CTRL, 8'he7);
    wr(12'h0f0, 8'h33);
    rd(12'h0f0, d);
    wr(CTRL, 8'h18);
    rd(12'hf85, d);
    wr(CTRL, 8'he0);
    chk_ctrl("split_unlock", 8'he0);
    // Frozen clock enable drops a full unlock sequence
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr_ctrl(8'h20);
    clk_en <= 1'b1;
    chk_ctrl("frozen", 8'he0);
    wr(CTRL, 8'h20);
    chk_ctrl("relocked", 8'he0);
    lf = 8'h2d;
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      d  = {1'b1, lf[6:5], 5'h00};
      wr_ctrl(d);
      chk_ctrl("rand_ctrl", d);
      chk_val("rand_en", {4'h0, d[7], d[6], d[5], d[6]}, {4'h0, en});
    end
    // Crystal on and settled before any select
    wr_ctrl(8'he0);
    repeat (20) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      wr_ctrl({5'h1c, i[2:0]});
      if (i > 0 && i < 5) begin
        @(posedge core_clk);
        #1 chk_val("gate_gap", 8'h00, {3'h0, sysclk_gate});
      end
      repeat (6) @(posedge core_clk);
      #1 chk_val("gate_sel", gate_exp(i), {3'h0, sysclk_gate});
      chk_ctrl("sel_store", {5'h1c, i[2:0]});
      chk_val("rc_kept", 8'h01, {7'h00, internal_rc_enable});
    end
    wr_ctrl(8'h62);
    #1 chk_val("rc_off", 8'h07, {4'h0, en});
    // Primary failure with recovery
    wr_ctrl(8'ha0);
    wr_ctrl(8'hb0);
    osc_run <= 4'he;
    wait_sig(0, 200, n);
    chk_rng("pri_fail_lat", PRI - 5, PRI + 5, n);
    chk_ctrl("recovered", 8'hb3);
    repeat (6) @(posedge core_clk);
    #1 chk_val("gate_wdt", 8'h08, {3'h0, sysclk_gate});
    // No recovery without the watchdog oscillator
    do_reset();
    wr_ctrl(8'h90);
    osc_run <= 4'he;
    wait_sig(0, 200, n);
    chk_rng("pri_fail_nowdt", PRI - 5, PRI + 5, n);
    chk_ctrl("no_recover", 8'h90);
    // Watchdog oscillator failure
    do_reset();
    wr_ctrl(8'ha8);
    osc_run <= 4'hb;
    wait_sig(1, 300, n);
    chk_rng("wdt_fail_lat", WDT * 4 - 20, WDT * 4 + 5, n);
    chk_ctrl("sel_kept", 8'ha8);
    wr_ctrl(8'hb0);
    osc_run <= 4'ha;
    n = 0;
    repeat (3 * PRI) begin
      @(posedge core_clk);
      #1 if (sysclk_fail_event !== 1'b0) n++;
    end
    chk_rng("pri_dead", 0, 0, n);
    // Precision oscillator and detection off, watchdog oscillator left on
    do_reset();
    wr_ctrl(8'h20);
    wait_sig(2, 10, n);
    chk_rng("stop_lat", 1, 3, n);
    repeat (2) @(posedge core_clk);
    #1 chk_val("stop_gate", 8'h00, {3'h0, sysclk_gate});
    finish_test();
  end
endmodule
